//--- rtl/sdlc_pkg.sv
// Package for the serial-lane configuration register bank.
// Assumes a plain register port with byte addresses and 32-bit data.
package sdlc_pkg;
  localparam int LANES = 4;
  localparam int AW = 8;
  // Register byte offsets: PLL first, then RX/TX pairs per lane
  localparam logic [7:0] PLL_OFS = 8'h00;
  localparam logic [7:0] RX0_OFS = 8'h04;
  localparam logic [7:0] TX0_OFS = 8'h08;
  localparam logic [7:0] LANE_STRIDE = 8'h08;
  // Writable bit masks; all other bits are driven by the block or reserved
  localparam logic [31:0] PLL_SW_MASK = 32'h00001BFE;
  localparam logic [31:0] RX_SW_MASK = 32'h007FF3F0;
  localparam logic [31:0] TX_SW_MASK = 32'hFFCFFFBE;
  // Reset values of the software fields
  localparam logic [31:0] PLL_RST = 32'h00000050;
  localparam logic [31:0] RX_RST = 32'h00444080;
  localparam logic [31:0] TX_RST = 32'h000EE384;
  // PLL field positions
  localparam int PLL_EN_BIT = 0;
  localparam int MPY_LSB = 1;
  localparam int MPY_MSB = 8;
  localparam logic [7:0] MPY_MIN_X4 = 8'h10;
  localparam logic [7:0] MPY_MAX_X4 = 8'h64;
  // Shared lane field positions
  localparam int LANE_ON_BIT = 0;
  localparam int WIDTH_LSB = 1;
  localparam int WIDTH_MSB = 3;
  localparam logic [2:0] WIDTH_20BIT = 3'h2;
  localparam int RATE_LSB = 4;
  localparam int RATE_MSB = 5;
  localparam int POL_BIT = 6;
  // RX field positions
  localparam int ALIGN_LSB = 10;
  localparam int ALIGN_MSB = 11;
  localparam int LOS_LSB = 12;
  localparam int LOS_MSB = 14;
  localparam int CDR_LSB = 15;
  localparam int CDR_MSB = 17;
  localparam int RXWRAP_LSB = 23;
  localparam int RXWRAP_MSB = 24;
  localparam logic [2:0] LOS_ON = 3'h4;
  // TX field positions
  localparam int AMP_LSB = 7;
  localparam int AMP_MSB = 10;
  localparam int PRE_LSB = 11;
  localparam int PRE_MSB = 13;
  localparam int POST_LSB = 14;
  localparam int POST_MSB = 18;
  localparam int TAP_UPD_BIT = 19;
  localparam int SYNC_MST_BIT = 20;
  localparam int TXWRAP_LO_BIT = 21;
  localparam int TXWRAP_HI_BIT = 22;
  // Tap weight step in tenths of a percent (2.5 %)
  localparam logic [9:0] TAP_STEP = 10'h019;
endpackage

//--- rtl/sdlc_regs.sv
// Configuration register bank for a four-lane serial transceiver:
// shared PLL word plus one RX and one TX word per lane.
// Assumes link control bits arrive as synchronous levels on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sdlc_regs
  import sdlc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic link_reset,
  input wire logic internal_loopback_flag,
  input wire logic [LANES-1:0] polarity_flip_req,
  input wire logic byte_clk_en,
  output logic [31:0] pll_cfg_out,
  output logic [LANES-1:0][31:0] rx_cfg_out,
  output logic [LANES-1:0][31:0] tx_cfg_out,
  output logic [7:0] pll_mult_x4,
  output logic pll_mult_ok,
  output logic [LANES-1:0] cdr_second_order,
  output logic [LANES-1:0][9:0] cdr_track_ppm,
  output logic [LANES-1:0] los_enable,
  output logic [LANES-1:0][3:0] rx_samples_x2,
  output logic [LANES-1:0][3:0] tx_samples_x2,
  output logic [LANES-1:0][9:0] post_weight_tenths,
  output logic [LANES-1:0][9:0] pre_weight_tenths,
  output logic [LANES-1:0][3:0] tx_amplitude
);

  // Samples per PLL cycle, times two, for a rate code
  function automatic logic [3:0] rate_samples(input logic [1:0] code);
    logic [3:0] s;
    s = 4'h0;
    case (code)
      2'h0: s = 4'h8;
      2'h1: s = 4'h4;
      2'h2: s = 4'h2;
      default: s = 4'h1;
    endcase
    return s;
  endfunction

  // Tracking rate in ppm for each clock recovery code
  function automatic logic [9:0] cdr_ppm(input logic [2:0] code);
    logic [9:0] p;
    p = 10'h000;
    case (code)
      3'h0: p = 10'h139;
      3'h1: p = 10'h25F;
      3'h2: p = 10'h2D3;
      3'h3: p = 10'h364;
      3'h4: p = 10'h060;
      3'h5: p = 10'h121;
      3'h6: p = 10'h1B2;
      default: p = 10'h00D;
    endcase
    return p;
  endfunction

  logic [31:0] pll_sw_q;
  logic [LANES-1:0][31:0] rx_sw_q;
  logic [LANES-1:0][31:0] tx_sw_q;
  logic [LANES-1:0][7:0] tap_q;
  logic [31:0] rdata_d;

  // Software writes to the PLL word; reserved and driven bits never stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_sw_q <= PLL_RST;
    end else if (reg_wr && reg_addr == PLL_OFS) begin
      pll_sw_q <= reg_wdata & PLL_SW_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      localparam logic [7:0] RX_ADDR = RX0_OFS + LANE_STRIDE * 8'(g);
      localparam logic [7:0] TX_ADDR = TX0_OFS + LANE_STRIDE * 8'(g);

      // Separate RX and TX words per lane
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rx_sw_q[g] <= RX_RST;
        end else if (reg_wr && reg_addr == RX_ADDR) begin
          rx_sw_q[g] <= reg_wdata & RX_SW_MASK;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          tx_sw_q[g] <= TX_RST;
        end else if (reg_wr && reg_addr == TX_ADDR) begin
          tx_sw_q[g] <= reg_wdata & TX_SW_MASK;
        end
      end

      // Tap weights only move on a byte clock beat with updates allowed;
      // this keeps a half-written weight pair off the driver.
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          tap_q[g] <= TX_RST[POST_MSB:PRE_LSB];
        end else if (byte_clk_en && tx_sw_q[g][TAP_UPD_BIT]) begin
          tap_q[g] <= tx_sw_q[g][POST_MSB:PRE_LSB];
        end
      end

      // Effective RX word: software fields merged with block-driven fields
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          rx_cfg_out[g] <= 32'h00000000;
        end else begin
          rx_cfg_out[g] <= rx_sw_q[g];
          rx_cfg_out[g][RXWRAP_MSB:RXWRAP_LSB] <= {2{internal_loopback_flag}};
          if (internal_loopback_flag) begin
            rx_cfg_out[g][LOS_MSB:LOS_LSB] <= 3'h0;
          end
          rx_cfg_out[g][ALIGN_MSB:ALIGN_LSB] <= 2'h0;
          rx_cfg_out[g][POL_BIT] <= polarity_flip_req[g];
          rx_cfg_out[g][WIDTH_MSB:WIDTH_LSB] <= WIDTH_20BIT;
          rx_cfg_out[g][LANE_ON_BIT] <= ~link_reset;
        end
      end

      // Effective TX word; tap fields come from the gated copy
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          tx_cfg_out[g] <= 32'h00000000;
        end else begin
          tx_cfg_out[g] <= tx_sw_q[g];
          tx_cfg_out[g][POST_MSB:PRE_LSB] <= tap_q[g];
          tx_cfg_out[g][TXWRAP_LO_BIT] <= internal_loopback_flag;
          tx_cfg_out[g][TXWRAP_HI_BIT] <= internal_loopback_flag
                                          & tx_sw_q[g][TXWRAP_HI_BIT];
          tx_cfg_out[g][SYNC_MST_BIT] <= 1'b1;
          tx_cfg_out[g][POL_BIT] <= polarity_flip_req[g];
          tx_cfg_out[g][LANE_ON_BIT] <= ~link_reset;
        end
      end

      // Decoded receive settings
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cdr_second_order[g] <= 1'b0;
          cdr_track_ppm[g] <= 10'h000;
          los_enable[g] <= 1'b0;
          rx_samples_x2[g] <= 4'h0;
        end else begin
          cdr_second_order[g] <= ~rx_sw_q[g][CDR_MSB];
          cdr_track_ppm[g] <= cdr_ppm(rx_sw_q[g][CDR_MSB:CDR_LSB]);
          los_enable[g] <= !internal_loopback_flag
                           && rx_sw_q[g][LOS_MSB:LOS_LSB] == LOS_ON;
          rx_samples_x2[g] <= rate_samples(rx_sw_q[g][RATE_MSB:RATE_LSB]);
        end
      end

      // Decoded transmit settings; weights in tenths of a percent
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          tx_samples_x2[g] <= 4'h0;
          post_weight_tenths[g] <= 10'h000;
          pre_weight_tenths[g] <= 10'h000;
          tx_amplitude[g] <= 4'h0;
        end else begin
          tx_samples_x2[g] <= rate_samples(tx_sw_q[g][RATE_MSB:RATE_LSB]);
          if (tap_q[g][7]) begin
            post_weight_tenths[g] <= 10'(0 - TAP_STEP * {6'h00, tap_q[g][6:3]});
          end else begin
            post_weight_tenths[g] <= 10'(TAP_STEP * {6'h00, tap_q[g][6:3]});
          end
          pre_weight_tenths[g] <= 10'(0 - TAP_STEP * {7'h00, tap_q[g][2:0]});
          tx_amplitude[g] <= tx_sw_q[g][AMP_MSB:AMP_LSB];
        end
      end

      // Assertions for this lane
      rx_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> rx_cfg_out[g][RXWRAP_MSB:RXWRAP_LSB]
                         == {2{$past(internal_loopback_flag)}})
        else $error("RX wrap field does not follow loopback");
      los_forced_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(internal_loopback_flag) |->
          rx_cfg_out[g][LOS_MSB:LOS_LSB] == 3'h0 && !los_enable[g])
        else $error("Loss detect active during loopback");
      rx_fixed_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> rx_cfg_out[g][WIDTH_MSB:WIDTH_LSB] == WIDTH_20BIT
                         && rx_cfg_out[g][ALIGN_MSB:ALIGN_LSB] == 2'h0)
        else $error("RX width or alignment not driven");
      lane_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> rx_cfg_out[g][LANE_ON_BIT] == !$past(link_reset)
                         && tx_cfg_out[g][LANE_ON_BIT] == !$past(link_reset))
        else $error("Lane enable does not follow link reset");
      tx_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && !$past(internal_loopback_flag) |->
          tx_cfg_out[g][TXWRAP_HI_BIT:TXWRAP_LO_BIT] == 2'h0)
        else $error("TX wrap field set outside loopback");
      sync_mst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> tx_cfg_out[g][SYNC_MST_BIT])
        else $error("Sync master bit not set");
      tap_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(byte_clk_en && tx_sw_q[g][TAP_UPD_BIT]) |=> $stable(tap_q[g]))
        else $error("Tap weights moved without update permission");
      tap_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_clk_en && tx_sw_q[g][TAP_UPD_BIT] |=>
          tap_q[g] == $past(tx_sw_q[g][POST_MSB:PRE_LSB]) ##1
          tx_cfg_out[g][POST_MSB:PRE_LSB] == $past(tap_q[g]))
        else $error("Tap weights not taken on update beat");
      post_sign_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(tap_q[g][6:3]) != 4'h0 |->
          post_weight_tenths[g][9] == $past(tap_q[g][7]))
        else $error("Post-cursor sign wrong");

      // Full post-cursor value, sign and magnitude together
      post_value_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> post_weight_tenths[g] == ($past(tap_q[g][7])
          ? 10'(0 - TAP_STEP * {6'h00, $past(tap_q[g][6:3])})
          : 10'(TAP_STEP * {6'h00, $past(tap_q[g][6:3])})))
        else $error("Post-cursor weight wrong");

      // Pre-cursor is never positive; code n gives n steps below zero
      pre_value_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |->
          pre_weight_tenths[g] == 10'(0 - TAP_STEP * {7'h00, $past(tap_q[g][2:0])}))
        else $error("Pre-cursor weight wrong");

      // Amplitude code passes straight through; levels rise with the code
      amp_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> tx_amplitude[g] == $past(tx_sw_q[g][AMP_MSB:AMP_LSB]))
        else $error("Amplitude code not passed through");

      // Rate code n gives eight half-samples shifted down by n
      rate_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |->
          rx_samples_x2[g] == (4'h8 >> $past(rx_sw_q[g][RATE_MSB:RATE_LSB]))
          && tx_samples_x2[g] == (4'h8 >> $past(tx_sw_q[g][RATE_MSB:RATE_LSB])))
        else $error("Rate decode wrong");

      // Upper half of the recovery codes is first order
      cdr_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |->
          cdr_second_order[g] == ($past(rx_sw_q[g][CDR_MSB:CDR_LSB]) < 3'h4))
        else $error("Clock recovery order wrong");

      // Tracking rates of the second-order codes
      cdr_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) && $past(rx_sw_q[g][CDR_MSB]) == 1'b0 |->
          cdr_track_ppm[g] == ($past(rx_sw_q[g][16:15]) == 2'h0 ? 10'h139 :
                               $past(rx_sw_q[g][16:15]) == 2'h1 ? 10'h25F :
                               $past(rx_sw_q[g][16:15]) == 2'h2 ? 10'h2D3 : 10'h364))
        else $error("Clock recovery rate wrong");

      // Detection is on only for the enable code outside loopback
      los_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> los_enable[g] == (!$past(internal_loopback_flag)
          && $past(rx_sw_q[g][LOS_MSB:LOS_LSB]) == LOS_ON))
        else $error("Loss detect enable wrong");

      // Both directions follow the link's polarity request
      pol_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |-> rx_cfg_out[g][POL_BIT] == $past(polarity_flip_req[g])
                         && tx_cfg_out[g][POL_BIT] == $past(polarity_flip_req[g]))
        else $error("Polarity bit does not follow request");
    end
  endgenerate

  // Effective PLL word and decoded multiplier
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_cfg_out <= 32'h00000000;
      pll_mult_x4 <= 8'h00;
      pll_mult_ok <= 1'b0;
    end else begin
      pll_cfg_out <= pll_sw_q;
      pll_cfg_out[PLL_EN_BIT] <= ~link_reset;
      pll_mult_x4 <= pll_sw_q[MPY_MSB:MPY_LSB];
      pll_mult_ok <= pll_sw_q[MPY_MSB:MPY_LSB] >= MPY_MIN_X4
                     && pll_sw_q[MPY_MSB:MPY_LSB] <= MPY_MAX_X4;
    end
  end

  // Read mux shows the effective words, so block-driven fields are visible.
  // Unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_addr == PLL_OFS) begin
      rdata_d = pll_cfg_out;
    end
    for (int i = 0; i < LANES; i++) begin
      if (reg_addr == RX0_OFS + LANE_STRIDE * i[7:0]) begin
        rdata_d = rx_cfg_out[i];
      end
      if (reg_addr == TX0_OFS + LANE_STRIDE * i[7:0]) begin
        rdata_d = tx_cfg_out[i];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  pll_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pll_cfg_out[PLL_EN_BIT] == !$past(link_reset))
    else $error("PLL enable does not follow link reset");
  mult_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pll_mult_ok |-> pll_mult_x4 >= 8'h10 && pll_mult_x4 <= 8'h64)
    else $error("Multiplier flagged valid out of range");
  reserved_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == PLL_OFS |=> reg_rdata[31:13] == 19'h00000
                                      && !reg_rdata[10])
    else $error("PLL reserved bits read nonzero");
  rx_resv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == RX0_OFS |=> reg_rdata[31:25] == 7'h00)
    else $error("RX reserved bits read nonzero");

  // Multiplier output is the stored code one cycle on
  mult_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pll_mult_x4 == $past(pll_sw_q[MPY_MSB:MPY_LSB]))
    else $error("Multiplier code not passed through");

  // Read data must not linger; a stale word could be taken as a fresh read
  rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("Read data stands outside its cycle");

  // Reserved top of every RX word reads zero, not only lane zero
  rx_resv_all_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> rx_cfg_out[1][31:25] == 7'h00 && rx_cfg_out[2][31:25] == 7'h00
                     && rx_cfg_out[3][31:25] == 7'h00)
    else $error("RX reserved bits set in a lane word");

endmodule

`default_nettype wire

//--- verification/sdlc_link_model.sv
// Model of the owning link module's control side for the register bank.
// Assumes the bench hands it level commands on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sdlc_link_model
  import sdlc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rst_cmd,
  input wire logic loop_cmd,
  input wire logic [LANES-1:0] pol_cmd,
  input wire logic beat_on,
  output logic link_reset,
  output logic internal_loopback_flag,
  output logic [LANES-1:0] polarity_flip_req,
  output logic byte_clk_en
);
  logic [1:0] div_q;

  // Control bits leave the link's own register as clean levels
  always_ff @(posedge clk_sys) begin
    link_reset <= rst_cmd;
    internal_loopback_flag <= loop_cmd;
    polarity_flip_req <= pol_cmd;
  end

  // Byte clock high one cycle in four; a slow beat shows whether taps wait for it
  always_ff @(posedge clk_sys) begin
    div_q <= rst_n ? div_q + 2'h1 : 2'h0;
    byte_clk_en <= beat_on && div_q == 2'h3;
  end
endmodule

`default_nettype wire

//--- verification/sdlc_regs_tb.sv
// Self-checking bench for the serial-lane configuration register bank.
// Assumes the package and the link model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module sdlc_regs_tb
  import sdlc_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sdlc_row_t;
  logic clk_sys, rst_n, reg_wr, reg_rd, rst_cmd, loop_cmd, beat_on;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pll_cfg_out;
  logic [LANES-1:0] pol_cmd, cdr_second_order, los_enable;
  logic [LANES-1:0][31:0] rx_cfg_out, tx_cfg_out;
  logic [LANES-1:0][9:0] cdr_track_ppm, post_weight_tenths, pre_weight_tenths;
  logic [LANES-1:0][3:0] rx_samples_x2, tx_samples_x2, tx_amplitude;
  logic [7:0] pll_mult_x4;
  logic pll_mult_ok, link_reset, internal_loopback_flag, byte_clk_en;
  logic [LANES-1:0] polarity_flip_req;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int ppm_tab [8] = '{313, 607, 723, 868, 96, 289, 434, 13};
  logic [7:0] mv [4] = '{8'h0F, 8'h10, 8'h64, 8'h65};
  // Plain bus traffic: write (or not), then read back the effective word
  sdlc_row_t rows [8] = '{
    '{1'b1, 8'h00, 32'hFFFFFFFF, 32'h00001BFF},
    '{1'b1, 8'h00, 32'h00000050, 32'h00000051},
    '{1'b1, 8'h04, 32'h0046C080, 32'h0046C085},
    '{1'b1, 8'h1C, 32'hFFFFFFBF, 32'h007FF3B5},
    '{1'b1, 8'h10, 32'h000EE784, 32'h001EE785},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h00000000},
    '{1'b0, 8'h0C, 32'h00000000, 32'h00444085},
    '{1'b0, 8'h18, 32'h00000000, 32'h001EE385}};

  sdlc_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_reset(link_reset),
    .internal_loopback_flag(internal_loopback_flag), .polarity_flip_req(polarity_flip_req),
    .byte_clk_en(byte_clk_en), .pll_cfg_out(pll_cfg_out), .rx_cfg_out(rx_cfg_out),
    .tx_cfg_out(tx_cfg_out), .pll_mult_x4(pll_mult_x4), .pll_mult_ok(pll_mult_ok),
    .cdr_second_order(cdr_second_order), .cdr_track_ppm(cdr_track_ppm),
    .los_enable(los_enable), .rx_samples_x2(rx_samples_x2), .tx_samples_x2(tx_samples_x2),
    .post_weight_tenths(post_weight_tenths), .pre_weight_tenths(pre_weight_tenths),
    .tx_amplitude(tx_amplitude));
  sdlc_link_model link_model (.clk_sys(clk_sys), .rst_n(rst_n), .rst_cmd(rst_cmd),
    .loop_cmd(loop_cmd), .pol_cmd(pol_cmd), .beat_on(beat_on), .link_reset(link_reset),
    .internal_loopback_flag(internal_loopback_flag), .polarity_flip_req(polarity_flip_req),
    .byte_clk_en(byte_clk_en));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands one cycle only, so both that cycle and the next are looked at
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    tick(1);
    chk("reg_rdata idle", 32'h0, reg_rdata);
  endtask

  // Hang guard, well above the length of the sequence below
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rst_cmd = 1'b0;
    loop_cmd = 1'b0;
    pol_cmd = 4'h0;
    beat_on = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(2);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    foreach (mv[i]) begin
      wr(PLL_OFS, {23'h0, mv[i], 1'b0});
      tick(3);
      chk("pll_mult_x4", 32'(mv[i]), 32'(pll_mult_x4));
      chk("pll_mult_ok", 32'(mv[i] inside {[8'h10:8'h64]}), 32'(pll_mult_ok));
    end
    wr(PLL_OFS, 32'h00000050);
    for (int c = 0; c < 8; c++) begin
      wr(RX0_OFS, 32'h00444080 | (32'(c) << 15) | (32'(c % 4) << 4));
      wr(TX0_OFS, 32'h000EE384 | (32'(c % 4) << 4));
      tick(3);
      chk("cdr_second_order", 32'(c < 4), 32'(cdr_second_order[0]));
      chk("cdr_track_ppm", 32'(ppm_tab[c]), 32'(cdr_track_ppm[0]));
      chk("rx_samples_x2", 32'(8 >> (c % 4)), 32'(rx_samples_x2[0]));
      chk("tx_samples_x2", 32'(8 >> (c % 4)), 32'(tx_samples_x2[0]));
    end
    wr(TX0_OFS, 32'h004EE384);
    chk("los_enable", 32'h1, 32'(los_enable[0]));
    loop_cmd <= 1'b1;
    tick(3);
    chk("rx wrap", 32'h3, 32'(rx_cfg_out[0][24:23]));
    chk("los_enable loop", 32'h0, 32'(los_enable[0]));
    chk("tx0 wrap", 32'h3, 32'(tx_cfg_out[0][22:21]));
    chk("tx1 wrap", 32'h1, 32'(tx_cfg_out[1][22:21]));
    loop_cmd <= 1'b0;
    rst_cmd <= 1'b1;
    pol_cmd <= 4'h4;
    tick(3);
    chk("rx wrap off", 32'h0, 32'(rx_cfg_out[0][24:23]));
    chk("tx0 wrap off", 32'h0, 32'(tx_cfg_out[0][22:21]));
    chk("pll enable", 32'h0, 32'(pll_cfg_out[0]));
    chk("rx on", 32'h0, 32'(rx_cfg_out[3][0]));
    chk("tx on", 32'h0, 32'(tx_cfg_out[2][0]));
    chk("rx2 flip", 32'h1, 32'(rx_cfg_out[2][6]));
    chk("tx2 flip", 32'h1, 32'(tx_cfg_out[2][6]));
    chk("rx1 flip", 32'h0, 32'(rx_cfg_out[1][6]));
    rst_cmd <= 1'b0;
    beat_on <= 1'b0;
    wr(TX0_OFS, 32'h000BFD04);
    tick(6);
    chk("post held", 32'h2ED, 32'(post_weight_tenths[0]));
    chk("tx_amplitude", 32'hA, 32'(tx_amplitude[0]));
    chk("pll enable on", 32'h1, 32'(pll_cfg_out[0]));
    beat_on <= 1'b1;
    tick(6);
    chk("post +37.5", 32'h177, 32'(post_weight_tenths[0]));
    chk("pre -17.5", 32'h351, 32'(pre_weight_tenths[0]));
    wr(TX0_OFS, 32'h00044504);
    tick(8);
    chk("post no allow", 32'h177, 32'(post_weight_tenths[0]));
    wr(TX0_OFS, 32'h000C4504);
    tick(8);
    chk("post -2.5", 32'h3E7, 32'(post_weight_tenths[0]));
    chk("pre 0", 32'h0, 32'(pre_weight_tenths[0]));
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(2);
    chk("pll in reset", 32'h0, pll_cfg_out);
    rst_n <= 1'b1;
    tick(2);
    rd(PLL_OFS, 32'h00000051);
    rd(TX0_OFS, 32'h001EE385);
    complete_run();
  end
endmodule

`default_nettype wire
